//--- design/ssb_cond.sv
// Mode switch condition test, one per selector code 0 to 3
`timescale 1ns/10ps
`default_nettype none
module ssb_cond (
	input wire logic [2:0] sel, // Mode switch selector
	input wire ssb_pkg::ssb_cfg_t cfg, // Levels
	input wire ssb_pkg::ssb_loop_t loop, // Loop quantities
	output logic hold // Condition holds
);
	function automatic logic over16(input logic signed [15:0] v,
		input logic [15:0] lvl);
		return ssb_pkg::ssb_abs32(32'(v)) > {16'h0000, lvl};
	endfunction

	always_comb begin
		case (sel)
			ssb_pkg::SEL_TRQ: hold = over16(loop.torque_ref,
				cfg.torque_switch_level);
			ssb_pkg::SEL_SPD: hold = over16(loop.speed_ref,
				cfg.speed_switch_level);
			ssb_pkg::SEL_ACC: hold = over16(loop.accel,
				cfg.accel_switch_level);
			ssb_pkg::SEL_ERR: hold = loop.pos_mode
				&& ssb_pkg::ssb_abs32(loop.err_pulse)
				> {16'h0000, cfg.error_pulse_switch_level};
			default: hold = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

//--- design/ssb_regs.sv
// Wishbone register file holding the bias and mode switch settings
//
// The register addresses and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module ssb_regs (
	input wire logic ref_clk, // Clock
	input wire logic rst_b, // Sync reset, low active
	input wire logic clk_en, // Freeze when low
	input wire logic wb_cyc_i, // Bus cycle
	input wire logic wb_stb_i, // Strobe
	input wire logic wb_we_i, // Write
	input wire logic [4:0] wb_adr_i, // Byte address
	input wire logic [3:0] wb_sel_i, // Byte lanes
	input wire logic [31:0] wb_dat_i, // Write data
	output logic [31:0] wb_dat_o, // Read data
	output logic wb_ack_o, // Acknowledge
	input wire logic [1:0] stat_i, // Bias active, P control
	output ssb_pkg::ssb_cfg_t cfg_o // Settings
);
	ssb_pkg::ssb_cfg_t cfg_q, cfg_d;
	logic ack_q, ack_d;
	logic [31:0] dat_q, dat_d;
	logic req;

	assign req = wb_cyc_i && wb_stb_i && !ack_q;

	// Low two lanes carry the 16 bit fields
	function automatic logic [15:0] lane16(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] s);
		return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	// Out of range values are clipped so the loop never sees them
	function automatic logic [15:0] clip(input logic [15:0] v,
		input logic [15:0] lim);
		return (v > lim) ? lim : v;
	endfunction

	// ============================================================
	// Decode
	always_comb begin
		cfg_d = cfg_q;
		ack_d = req;
		dat_d = 32'h00000000;
		if (req && wb_we_i) begin
			if (wb_adr_i == ssb_pkg::ADR_BIAS) begin
				cfg_d.speed_bias_amount = clip(lane16(cfg_q.speed_bias_amount,
					wb_dat_i, wb_sel_i), ssb_pkg::BIAS_MAX);
			end else if (wb_adr_i == ssb_pkg::ADR_WIDTH) begin
				cfg_d.bias_addition_width = clip(lane16(
					cfg_q.bias_addition_width, wb_dat_i, wb_sel_i),
					ssb_pkg::WIDTH_MAX);
			end else if (wb_adr_i == ssb_pkg::ADR_SEL) begin
				// Codes above 4 are refused, the selector keeps its value
				if (wb_sel_i[0] && wb_dat_i[7:0] <= 8'h04) begin
					cfg_d.mode_switch_selector = wb_dat_i[2:0];
				end
			end else if (wb_adr_i == ssb_pkg::ADR_TRQ) begin
				cfg_d.torque_switch_level = lane16(cfg_q.torque_switch_level,
					wb_dat_i, wb_sel_i);
			end else if (wb_adr_i == ssb_pkg::ADR_SPD) begin
				cfg_d.speed_switch_level = lane16(cfg_q.speed_switch_level,
					wb_dat_i, wb_sel_i);
			end else if (wb_adr_i == ssb_pkg::ADR_ACC) begin
				cfg_d.accel_switch_level = lane16(cfg_q.accel_switch_level,
					wb_dat_i, wb_sel_i);
			end else if (wb_adr_i == ssb_pkg::ADR_ERR) begin
				cfg_d.error_pulse_switch_level = lane16(
					cfg_q.error_pulse_switch_level, wb_dat_i, wb_sel_i);
			end
		end else if (req) begin
			if (wb_adr_i == ssb_pkg::ADR_BIAS) begin
				dat_d = {16'h0000, cfg_q.speed_bias_amount};
			end else if (wb_adr_i == ssb_pkg::ADR_WIDTH) begin
				dat_d = {16'h0000, cfg_q.bias_addition_width};
			end else if (wb_adr_i == ssb_pkg::ADR_SEL) begin
				dat_d = {29'h00000000, cfg_q.mode_switch_selector};
			end else if (wb_adr_i == ssb_pkg::ADR_TRQ) begin
				dat_d = {16'h0000, cfg_q.torque_switch_level};
			end else if (wb_adr_i == ssb_pkg::ADR_SPD) begin
				dat_d = {16'h0000, cfg_q.speed_switch_level};
			end else if (wb_adr_i == ssb_pkg::ADR_ACC) begin
				dat_d = {16'h0000, cfg_q.accel_switch_level};
			end else if (wb_adr_i == ssb_pkg::ADR_ERR) begin
				dat_d = {16'h0000, cfg_q.error_pulse_switch_level};
			end else if (wb_adr_i == ssb_pkg::ADR_STAT) begin
				dat_d = {30'h00000000, stat_i};
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			cfg_q.speed_bias_amount <= ssb_pkg::BIAS_RST;
			cfg_q.bias_addition_width <= ssb_pkg::WIDTH_RST;
			cfg_q.mode_switch_selector <= ssb_pkg::SEL_RST;
			cfg_q.torque_switch_level <= ssb_pkg::TRQ_RST;
			cfg_q.speed_switch_level <= ssb_pkg::SPD_RST;
			cfg_q.accel_switch_level <= ssb_pkg::ACC_RST;
			cfg_q.error_pulse_switch_level <= ssb_pkg::ERR_RST;
			ack_q <= 1'b0;
			dat_q <= 32'h00000000;
		end else if (clk_en) begin
			cfg_q <= cfg_d;
			ack_q <= ack_d;
			dat_q <= dat_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;
	assign cfg_o = cfg_q;

	chk_reset_defaults: assert property (@(posedge ref_clk)
		!rst_b |=> cfg_q.mode_switch_selector == ssb_pkg::SEL_TRQ
		&& cfg_q.torque_switch_level == ssb_pkg::TRQ_RST)
		else $error("reset defaults wrong");
	chk_bias_range: assert property (@(posedge ref_clk) disable iff (!rst_b)
		cfg_q.speed_bias_amount <= ssb_pkg::BIAS_MAX)
		else $error("bias out of range");
	chk_width_range: assert property (@(posedge ref_clk) disable iff (!rst_b)
		cfg_q.bias_addition_width <= ssb_pkg::WIDTH_MAX)
		else $error("width out of range");
	chk_sel_range: assert property (@(posedge ref_clk) disable iff (!rst_b)
		cfg_q.mode_switch_selector <= ssb_pkg::SEL_OFF)
		else $error("selector out of range");
endmodule
`default_nettype wire

//--- design/ssb_top.sv
// Speed bias and PI/P mode switch decision logic
`timescale 1ns/10ps
`default_nettype none
module ssb_top (
	input wire logic ref_clk, // Clock, 200 MHz
	input wire logic rst_b, // Sync reset, low active
	input wire logic clk_en, // Freeze when low
	input wire logic wb_cyc_i, // Bus cycle
	input wire logic wb_stb_i, // Strobe
	input wire logic wb_we_i, // Write
	input wire logic [4:0] wb_adr_i, // Byte address
	input wire logic [3:0] wb_sel_i, // Byte lanes
	input wire logic [31:0] wb_dat_i, // Write data
	output logic [31:0] wb_dat_o, // Read data
	output logic wb_ack_o, // Acknowledge
	input wire ssb_pkg::ssb_loop_t loop_i, // Loop quantities
	output logic signed [15:0] speed_ref_o, // Biased speed reference
	output logic bias_on_o, // Bias applied
	output logic p_ctrl_o // 1 P control, 0 PI
);
	ssb_pkg::ssb_cfg_t cfg;
	logic hold;
	logic signed [15:0] sref_q, sref_d;
	logic bias_q, bias_d, p_q, p_d;
	logic over;

	ssb_regs u_regs (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.clk_en(clk_en),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.stat_i({bias_q, p_q}),
		.cfg_o(cfg)
	);

	ssb_cond u_cond (
		.sel(cfg.mode_switch_selector),
		.cfg(cfg),
		.loop(loop_i),
		.hold(hold)
	);

	// ============================================================
	// Bias and mode decision
	always_comb begin
		over = ssb_pkg::ssb_abs32(loop_i.err_pulse)
			> {16'h0000, cfg.bias_addition_width};
		// Bias only belongs to position control
		bias_d = loop_i.pos_mode && over;
		if (bias_d && !loop_i.err_pulse[31]) begin
			sref_d = 16'(loop_i.speed_ref + $signed(cfg.speed_bias_amount));
		end else if (bias_d) begin
			sref_d = 16'(loop_i.speed_ref - $signed(cfg.speed_bias_amount));
		end else begin
			sref_d = loop_i.speed_ref;
		end
		p_d = hold;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			sref_q <= 16'sh0000;
			bias_q <= 1'b0;
			p_q <= 1'b0;
		end else if (clk_en) begin
			sref_q <= sref_d;
			bias_q <= bias_d;
			p_q <= p_d;
		end
	end

	assign speed_ref_o = sref_q;
	assign bias_on_o = bias_q;
	assign p_ctrl_o = p_q;

	chk_bias_gate: assert property (@(posedge ref_clk) disable iff (!rst_b)
		clk_en && !(loop_i.pos_mode && over) |=> !bias_on_o)
		else $error("bias applied inside width");
	chk_bias_sign: assert property (@(posedge ref_clk) disable iff (!rst_b)
		clk_en && bias_d && loop_i.err_pulse[31] |=> speed_ref_o ==
		16'($past(loop_i.speed_ref) - $signed($past(cfg.speed_bias_amount))))
		else $error("bias sign wrong");
	chk_p_follow: assert property (@(posedge ref_clk) disable iff (!rst_b)
		clk_en |=> p_ctrl_o == $past(hold))
		else $error("P control not following condition");
	chk_off_pi: assert property (@(posedge ref_clk) disable iff (!rst_b)
		clk_en && cfg.mode_switch_selector == ssb_pkg::SEL_OFF |=> !p_ctrl_o)
		else $error("switching while disabled");
	chk_err_posmode: assert property (@(posedge ref_clk) disable iff (!rst_b)
		clk_en && cfg.mode_switch_selector == ssb_pkg::SEL_ERR
		&& !loop_i.pos_mode |=> !p_ctrl_o)
		else $error("error test outside position mode");
endmodule
`default_nettype wire

//--- inc/ssb_pkg.sv
// Constants and carrier types for the speed bias and mode switch block
// ============================================================
// Summary of operation
// - Speed bias setting 0 to 450 rpm, reset 0, added to speed reference with the sign of the error.
// - Bias addition width 0 to 250 error pulses, reset 7.
// - Bias applies only while error magnitude exceeds the addition width.
// - Selector: 0 torque, 1 speed, 2 accel, 3 error pulse, 4 off.
// - P control while the selected condition holds, PI otherwise.
// - Selector 0: P while torque reference exceeds torque level (percent).
// - Reset defaults: selector torque test, torque level 200 percent.
// - Selector 1: P while speed reference exceeds speed level (rpm).
// - Selector 2: P while acceleration exceeds level in 10 rpm/s units.
// - Selector 3: P while error pulses exceed the error pulse level.
// - Error pulse test acts only in position control mode.
package ssb_pkg;
	// ============================================================
	// Register map, byte offsets on the bus
	localparam logic [4:0] ADR_BIAS = 5'h00;
	localparam logic [4:0] ADR_WIDTH = 5'h04;
	localparam logic [4:0] ADR_SEL = 5'h08;
	localparam logic [4:0] ADR_TRQ = 5'h0C;
	localparam logic [4:0] ADR_SPD = 5'h10;
	localparam logic [4:0] ADR_ACC = 5'h14;
	localparam logic [4:0] ADR_ERR = 5'h18;
	localparam logic [4:0] ADR_STAT = 5'h1C;
	// ============================================================
	// Reset values and limits
	localparam logic [15:0] BIAS_RST = 16'h0000;
	localparam logic [15:0] BIAS_MAX = 16'h01C2;
	localparam logic [15:0] WIDTH_RST = 16'h0007;
	localparam logic [15:0] WIDTH_MAX = 16'h00FA;
	localparam logic [2:0] SEL_RST = 3'h0;
	localparam logic [15:0] TRQ_RST = 16'h00C8;
	localparam logic [15:0] SPD_RST = 16'h0000;
	localparam logic [15:0] ACC_RST = 16'h0000;
	localparam logic [15:0] ERR_RST = 16'h0000;
	// ============================================================
	// Selector codes
	localparam logic [2:0] SEL_TRQ = 3'h0;
	localparam logic [2:0] SEL_SPD = 3'h1;
	localparam logic [2:0] SEL_ACC = 3'h2;
	localparam logic [2:0] SEL_ERR = 3'h3;
	localparam logic [2:0] SEL_OFF = 3'h4;

	typedef struct packed {
		logic [15:0] speed_bias_amount;
		logic [15:0] bias_addition_width;
		logic [2:0] mode_switch_selector;
		logic [15:0] torque_switch_level;
		logic [15:0] speed_switch_level;
		logic [15:0] accel_switch_level;
		logic [15:0] error_pulse_switch_level;
	} ssb_cfg_t;

	typedef struct packed {
		logic signed [15:0] torque_ref;
		logic signed [15:0] speed_ref;
		logic signed [15:0] accel;
		logic signed [31:0] err_pulse;
		logic pos_mode;
	} ssb_loop_t;

	function automatic logic [31:0] ssb_abs32(input logic signed [31:0] v);
		return v[31] ? 32'(-v) : 32'(v);
	endfunction
endpackage

//--- tb/ssb_host.sv
// Host motion controller model driving the loop quantities
`timescale 1ns/10ps
`default_nettype none
module ssb_host (
	input wire logic ref_clk, // Clock
	output var ssb_pkg::ssb_loop_t loop_o // Loop quantities
);
	initial loop_o = '0;

	// ============================================================
	// Drive
	// New values land just after an edge and stay until the next call
	task automatic put(input logic signed [15:0] trq,
		input logic signed [15:0] spd, input logic signed [15:0] acc,
		input logic signed [31:0] err, input logic pos);
		@(posedge ref_clk);
		loop_o <= '{trq, spd, acc, err, pos};
	endtask
endmodule
`default_nettype wire

//--- tb/tb.sv
// Self-checking testbench for the speed bias and mode switch block
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic clk_en = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [4:0] wb_adr_i = 5'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h00000000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic signed [15:0] speed_ref_o;
	logic bias_on_o;
	logic p_ctrl_o;
	ssb_pkg::ssb_loop_t loop_w;
	int bad_count = 0;
	int num_checks = 0;
	int cycles = 0;
	logic [15:0] lv [4];
	logic [15:0] q [4];
	logic [15:0] rv [7];

	always #2.5 ref_clk = ~ref_clk;

	ssb_host i_host (.ref_clk(ref_clk), .loop_o(loop_w));

	ssb_top i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .loop_i(loop_w),
		.speed_ref_o(speed_ref_o), .bias_on_o(bias_on_o),
		.p_ctrl_o(p_ctrl_o));

	// ============================================================
	// Tasks
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Entered right after an edge; ack and read data sampled at one edge
	task automatic wb_xfer(input logic we, input logic [4:0] adr,
		input logic [31:0] wd, output logic [31:0] rd);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= 4'hF;
		wb_dat_i <= wd;
		do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic wr(input logic [4:0] adr, input logic [31:0] d);
		logic [31:0] x;
		wb_xfer(1'b1, adr, d, x);
	endtask

	task automatic rd(input logic [4:0] adr, input logic [31:0] exp);
		logic [31:0] x;
		wb_xfer(1'b0, adr, 32'h00000000, x);
		check("wb_dat_o", x, exp);
	endtask

	// Outputs answer one edge after the loop inputs are taken
	task automatic lchk(input logic [15:0] trq, input logic [15:0] spd,
		input logic [15:0] acc, input logic [31:0] err, input logic pos,
		input logic [15:0] e_spd, input logic e_b, input logic e_p);
		i_host.put(trq, spd, acc, err, pos);
		repeat (2) @(posedge ref_clk);
		check("speed_ref_o", {16'h0000, speed_ref_o}, {16'h0000, e_spd});
		check("bias_on_o", {31'h0, bias_on_o}, {31'h0, e_b});
		check("p_ctrl_o", {31'h0, p_ctrl_o}, {31'h0, e_p});
	endtask

	// ============================================================
	// Timeout
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			report_and_stop();
		end
	end

	// ============================================================
	// Main sequence
	initial begin
		rv = '{16'h0000, 16'h0007, 16'h0000, 16'h00C8, 16'h0000,
			16'h0000, 16'h0000};
		lv = '{16'h0032, 16'h01F4, 16'h001E, 16'h0014};
		repeat (4) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		for (int k = 0; k < 7; k++)
			rd(5'(4 * k), {16'h0000, rv[k]});
		wr(5'h02, 32'h0000FFFF);
		rd(5'h02, 32'h00000000);
		wr(ssb_pkg::ADR_BIAS, 32'h00000064);
		lchk(16'h0, 16'h03E8, 16'h0, 32'h8, 1'b1, 16'h044C, 1'b1, 1'b0);
		rd(ssb_pkg::ADR_STAT, 32'h00000002);
		lchk(16'h0, 16'h03E8, 16'h0, 32'h7, 1'b1, 16'h03E8, 1'b0, 1'b0);
		lchk(16'h0, 16'h03E8, 16'h0, -32'sd8, 1'b1, 16'h0384, 1'b1, 1'b0);
		lchk(16'h0, 16'h03E8, 16'h0, -32'sd7, 1'b1, 16'h03E8, 1'b0, 1'b0);
		wr(ssb_pkg::ADR_BIAS, 32'h000001F4);
		rd(ssb_pkg::ADR_BIAS, 32'h000001C2);
		wr(ssb_pkg::ADR_WIDTH, 32'h00000100);
		rd(ssb_pkg::ADR_WIDTH, 32'h000000FA);
		for (int k = 0; k < 4; k++)
			wr(ssb_pkg::ADR_TRQ + 5'(4 * k), {16'h0000, lv[k]});
		// Level plus zero must stay PI: the test is strictly greater
		for (int s = 0; s < 5; s++) begin
			wr(ssb_pkg::ADR_SEL, 32'(s));
			rd(ssb_pkg::ADR_SEL, 32'(s));
			for (int h = 0; h < 2; h++) begin
				for (int k = 0; k < 4; k++)
					q[k] = (k == s || s == 4) ? lv[k] + 16'(h) : 16'h0000;
				lchk(q[0], q[1], q[2], {16'h0000, q[3]}, 1'b1, q[1], 1'b0,
					1'(s < 4 && h == 1));
			end
		end
		wr(ssb_pkg::ADR_SEL, 32'h00000005);
		rd(ssb_pkg::ADR_SEL, 32'h00000004);
		wr(ssb_pkg::ADR_SEL, 32'h00000003);
		lchk(16'h0, 16'h0, 16'h0, 32'h15, 1'b1, 16'h0, 1'b0, 1'b1);
		lchk(16'h0, 16'h0, 16'h0, 32'h15, 1'b0, 16'h0, 1'b0, 1'b0);
		// Error beyond the width but outside position control: no bias
		lchk(16'h0, 16'h03E8, 16'h0, 32'h100, 1'b0, 16'h03E8, 1'b0, 1'b0);
		lchk(16'h0, 16'h03E8, 16'h0, 32'h100, 1'b1, 16'h05AA, 1'b1, 1'b1);
		// Enable low must hold every output at its last value
		clk_en <= 1'b0;
		i_host.put(16'h0, 16'h0, 16'h0, 32'h0, 1'b1);
		repeat (2) @(posedge ref_clk);
		check("speed_ref_o", {16'h0000, speed_ref_o}, 32'h000005AA);
		check("bias_on_o", {31'h0, bias_on_o}, 32'h00000001);
		check("p_ctrl_o", {31'h0, p_ctrl_o}, 32'h00000001);
		clk_en <= 1'b1;
		repeat (2) @(posedge ref_clk);
		check("speed_ref_o", {16'h0000, speed_ref_o}, 32'h00000000);
		check("p_ctrl_o", {31'h0, p_ctrl_o}, 32'h00000000);
		lchk(16'h0, 16'h03E8, 16'h0, 32'h100, 1'b1, 16'h05AA, 1'b1, 1'b1);
		// Reset in mid-run: outputs drop and settings return to defaults
		rst_b <= 1'b0;
		repeat (2) @(posedge ref_clk);
		check("p_ctrl_o", {31'h0, p_ctrl_o}, 32'h00000000);
		check("bias_on_o", {31'h0, bias_on_o}, 32'h00000000);
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		rd(ssb_pkg::ADR_SEL, 32'h00000000);
		rd(ssb_pkg::ADR_TRQ, 32'h000000C8);
		rd(ssb_pkg::ADR_BIAS, 32'h00000000);
		rd(ssb_pkg::ADR_WIDTH, 32'h00000007);
		report_and_stop();
	end
endmodule
`default_nettype wire
